//--- rtl/pifm_sticky.sv
// sticky flag bank where a set beats a clear in the same cycle
`timescale 1ns/10ps
module pifm_sticky #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             reset_n_in,
   // set and clear
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic [WIDTH-1:0] clr_in,
   // stored flags
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] q_r;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q_r <= {WIDTH{1'b0}};
      end else begin
         q_r <= (q_r & ~clr_in) | set_in;
      end
   end

   assign q_out = q_r;

   a_set_wins: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (|set_in) |=> ((q_out & $past(set_in)) == $past(set_in)))
      else $error("sticky set lost against clear");
endmodule // pifm_sticky

//--- rtl/pifm_top.sv
// peripheral interrupt flag collector, line map, access gate, clock request
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
`include "pifm_map.svh"
// Behaviour
// - writing one clears that flag; writing zero leaves it alone
// - custom logic 23, touch 22, DAC 21, comparator 20, sigma-delta 19
// - the two converter flags sit in bits 17 and 18
// - basic timers zero to four sit in bits 12 to 16
// - control timers zero to two sit in bits 9 to 11
// - the CAN flag sits in bit 7
// - serial controllers zero to five in bits 1 to 6, event flag bit 0
// - event line 8; serial 0/6 line 9, 1/7 line 10, 2..5 lines 11..14
// - CAN 15,16; control timers 17..19; basic timer pairs 20..22, 23, 24
// - converters 25,26; comparator 27; DAC 28; sigma 29; touch 30; 31 idle
// - masked interface reads zero and drops writes
// - clock request passes only with peripheral, clock and generator on
module pifm_top #(
   parameter int unsigned N_CLK_REQ = 4
) (
   // clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   reset_n_in,
   // register port
   input  wire pifm_pkg::pifm_addr_type addr_in,
   input  wire pifm_pkg::pifm_word_type wdata_in,
   input  wire logic                   wr_in,
   input  wire logic                   rd_in,
   output pifm_pkg::pifm_word_type     rdata_out,
   // power manager interface mask
   input  wire logic                   iface_unmask_in,
   // flag raise pulses from the peripherals
   input  wire logic                   event_system_flag_set_in,
   input  wire logic [5:0]             serial_controller_flags_set_in,
   input  wire logic                   can_flag_set_in,
   input  wire logic [2:0]             control_timer_flags_set_in,
   input  wire logic [4:0]             basic_timer_flags_set_in,
   input  wire logic [1:0]             adc_flags_set_in,
   input  wire logic                   sigma_delta_converter_flag_set_in,
   input  wire logic                   comparator_flag_set_in,
   input  wire logic                   dac_flag_set_in,
   input  wire logic                   touch_controller_flag_set_in,
   input  wire logic                   custom_logic_flag_set_in,
   // interrupt requests from the peripherals
   input  wire logic                   event_req_in,
   input  wire logic [7:0]             serial_req_in,
   input  wire logic [1:0]             can_req_in,
   input  wire logic [2:0]             ctimer_req_in,
   input  wire logic [7:0]             btimer_req_in,
   input  wire logic [1:0]             adc_req_in,
   input  wire logic                   comparator_req_in,
   input  wire logic                   dac_req_in,
   input  wire logic                   sigma_req_in,
   input  wire logic                   touch_req_in,
   // processor interrupt lines
   output logic [31:0]                 irq_line_out,
   // clock request chain
   input  wire logic [N_CLK_REQ-1:0]   clk_req_in,
   input  wire logic [N_CLK_REQ-1:0]   periph_en_in,
   input  wire logic [N_CLK_REQ-1:0]   gen_clk_en_in,
   input  wire logic [N_CLK_REQ-1:0]   generator_en_in,
   output logic                        clk_src_req_out,
   // block interrupt
   output logic                        irq_out
);
   import pifm_pkg::*;

   pifm_flags_type flags_q;
   pifm_flags_type flag_set;
   pifm_flags_type flag_clr;
   pifm_stat_type  stat_q;
   pifm_stat_type  stat_set;
   pifm_stat_type  stat_clr;
   pifm_stat_type  mask_r;
   pifm_word_type  rdata_r;
   pifm_word_type  rdata_nxt;
   logic [31:0]    line_r;
   logic [31:0]    line_nxt;
   logic           clk_src_req_r;
   logic           irq_r;
   logic           wr_ok;
   logic           rd_ok;

   // the whole register window is closed while the interface is masked
   assign wr_ok = wr_in & iface_unmask_in;
   assign rd_ok = rd_in & iface_unmask_in;

   // assemble raise pulses in register layout
   always_comb begin
      flag_set = `PIFM_RST_FLAGS;
      flag_set[`PIFM_BIT_CUSTOM] = custom_logic_flag_set_in;
      flag_set[`PIFM_BIT_TOUCH] = touch_controller_flag_set_in;
      flag_set[`PIFM_BIT_DAC] = dac_flag_set_in;
      flag_set[`PIFM_BIT_CMP] = comparator_flag_set_in;
      flag_set[`PIFM_BIT_SIGMA] = sigma_delta_converter_flag_set_in;
      flag_set[`PIFM_BIT_ADC_LO +: `PIFM_N_ADC_FLAGS] =
         adc_flags_set_in;
      flag_set[`PIFM_BIT_BTIMER_LO +: `PIFM_N_BTIMER_FLAGS] =
         basic_timer_flags_set_in;
      flag_set[`PIFM_BIT_CTIMER_LO +: `PIFM_N_CTIMER_FLAGS] =
         control_timer_flags_set_in;
      flag_set[`PIFM_BIT_CAN] = can_flag_set_in;
      flag_set[`PIFM_BIT_SERIAL_LO +: `PIFM_N_SERIAL_FLAGS] =
         serial_controller_flags_set_in;
      flag_set[`PIFM_BIT_EVENT] = event_system_flag_set_in;
      // unimplemented positions never hold a flag
      flag_set = flag_set & `PIFM_FLAG_IMPL;
   end

   // one-to-clear; zeros and unimplemented bits are ignored
   always_comb begin
      flag_clr = `PIFM_RST_FLAGS;
      if (wr_ok && (addr_in == `PIFM_OFF_FLAG_CLR)) begin
         flag_clr = wdata_in[23:0] & `PIFM_FLAG_IMPL;
      end
   end

   pifm_sticky #(
      .WIDTH      (24)
   ) u_flags (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .set_in     (flag_set),
      .clr_in     (flag_clr),
      .q_out      (flags_q)
   );

   // block events: a new flag, or an access refused by the mask
   always_comb begin
      stat_set = `PIFM_RST_STAT;
      stat_set[`PIFM_STAT_RAISED] = |flag_set;
      stat_set[`PIFM_STAT_MASKED] = (wr_in | rd_in) & ~iface_unmask_in;
      stat_clr = `PIFM_RST_STAT;
      if (wr_ok && (addr_in == `PIFM_OFF_IRQ_STAT)) begin
         stat_clr = wdata_in[1:0];
      end
   end

   pifm_sticky #(
      .WIDTH      (2)
   ) u_stat (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .set_in     (stat_set),
      .clr_in     (stat_clr),
      .q_out      (stat_q)
   );

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mask_r <= `PIFM_RST_MASK;
      end else if (wr_ok && (addr_in == `PIFM_OFF_IRQ_MASK)) begin
         mask_r <= wdata_in[1:0];
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(stat_q & mask_r);
      end
   end

   // read data stand only in the cycle after the strobe
   always_comb begin
      rdata_nxt = `PIFM_RST_WORD;
      if (rd_ok) begin
         unique case (addr_in)
            `PIFM_OFF_FLAG_CLR: begin
               rdata_nxt = {8'h00, flags_q & `PIFM_FLAG_IMPL};
            end
            `PIFM_OFF_IRQ_STAT: begin
               rdata_nxt = {30'h00000000, stat_q};
            end
            `PIFM_OFF_IRQ_MASK: begin
               rdata_nxt = {30'h00000000, mask_r};
            end
            default: begin
               rdata_nxt = `PIFM_RST_WORD;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_r <= `PIFM_RST_WORD;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // fixed routing of peripheral requests onto processor lines
   always_comb begin
      line_nxt = 32'h00000000;
      line_nxt[`PIFM_LINE_EVENT] = event_req_in;
      line_nxt[`PIFM_LINE_SERIAL_LO] = serial_req_in[0] | serial_req_in[6];
      line_nxt[`PIFM_LINE_SERIAL_LO + 1] =
         serial_req_in[1] | serial_req_in[7];
      line_nxt[`PIFM_LINE_SERIAL_LO + 2 +: 4] = serial_req_in[5:2];
      line_nxt[`PIFM_LINE_CAN_LO +: 2] = can_req_in;
      line_nxt[`PIFM_LINE_CTIMER_LO +: 3] = ctimer_req_in;
      // timers 5..7 share a line with 0..2
      line_nxt[`PIFM_LINE_BTIMER_LO +: 3] =
         btimer_req_in[2:0] | btimer_req_in[7:5];
      line_nxt[`PIFM_LINE_BTIMER3] = btimer_req_in[3];
      line_nxt[`PIFM_LINE_BTIMER4] = btimer_req_in[4];
      line_nxt[`PIFM_LINE_ADC_LO +: 2] = adc_req_in;
      line_nxt[`PIFM_LINE_CMP] = comparator_req_in;
      line_nxt[`PIFM_LINE_DAC] = dac_req_in;
      line_nxt[`PIFM_LINE_SIGMA] = sigma_req_in;
      line_nxt[`PIFM_LINE_TOUCH] = touch_req_in;
      line_nxt[`PIFM_LINE_RSVD] = 1'b0;
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         line_r <= 32'h00000000;
      end else begin
         line_r <= line_nxt;
      end
   end

   // a request dies at the first disabled stage of its chain
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         clk_src_req_r <= 1'b0;
      end else begin
         clk_src_req_r <= |(clk_req_in & periph_en_in & gen_clk_en_in
                            & generator_en_in);
      end
   end

   assign rdata_out       = rdata_r;
   assign irq_line_out    = line_r;
   assign clk_src_req_out = clk_src_req_r;
   assign irq_out         = irq_r;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);

   a_clear_one: assert property (
      (wr_ok && addr_in == `PIFM_OFF_FLAG_CLR) |=>
      ((flags_q & $past(wdata_in[23:0]) & ~$past(flag_set)
        & `PIFM_FLAG_IMPL) == 24'h000000))
      else $error("flag written with one did not clear");

   a_zero_keeps: assert property (
      (wr_ok && addr_in == `PIFM_OFF_FLAG_CLR) |=>
      (($past(flags_q) & ~$past(wdata_in[23:0]) & ~flags_q)
        == 24'h000000))
      else $error("flag written with zero changed");

   a_custom_bit: assert property (
      custom_logic_flag_set_in |=> rd_ok && addr_in == `PIFM_OFF_FLAG_CLR
      |=> rdata_out[`PIFM_BIT_CUSTOM])
      else $error("custom logic flag not at its bit");

   a_read_layout: assert property (
      (rd_ok && addr_in == `PIFM_OFF_FLAG_CLR) |=>
      (rdata_out == {8'h00, $past(flags_q) & `PIFM_FLAG_IMPL}))
      else $error("flag read layout wrong");

   a_timer_bits: assert property (
      (basic_timer_flags_set_in[4] && control_timer_flags_set_in[0]) |=>
      (flags_q[16] && flags_q[9]))
      else $error("timer flag bit placement wrong");

   a_reserved_zero: assert property (
      (rdata_out[31:24] == 8'h00) && !rdata_out[8] && !flags_q[8])
      else $error("reserved flag bits not zero");

   a_line_shared: assert property (
      ##1 (irq_line_out[9] == $past(serial_req_in[0] | serial_req_in[6]))
      && (irq_line_out[8] == $past(event_req_in))
      && (irq_line_out[20] == $past(btimer_req_in[0] | btimer_req_in[5]))
      && (irq_line_out[24] == $past(btimer_req_in[4])))
      else $error("shared line routing wrong");

   a_line_analog: assert property (
      ##1 (irq_line_out[30] == $past(touch_req_in))
      && (irq_line_out[25] == $past(adc_req_in[0]))
      && !irq_line_out[31] && (irq_line_out[7:0] == 8'h00))
      else $error("analog line routing wrong");

   a_masked_read: assert property (
      (rd_in && !iface_unmask_in) |=> (rdata_out == `PIFM_RST_WORD))
      else $error("masked read returned data");

   a_masked_write: assert property (
      (wr_in && !iface_unmask_in) |=>
      (($past(flags_q) & ~flags_q) == 24'h000000) && $stable(mask_r))
      else $error("masked write took effect");

   a_clk_chain: assert property (
      ##1 (clk_src_req_out == $past(|(clk_req_in & periph_en_in
                                      & gen_clk_en_in & generator_en_in))))
      else $error("clock request passed a disabled stage");

   a_irq_level: assert property (
      ##1 (irq_out == $past(|(stat_q & mask_r))))
      else $error("interrupt level wrong");

   a_read_idle: assert property (
      !rd_ok |=> (rdata_out == `PIFM_RST_WORD))
      else $error("read data stood beyond its cycle");

   a_clr_scope: assert property (
      (wr_ok && addr_in != `PIFM_OFF_FLAG_CLR) |=>
      (($past(flags_q) & ~flags_q) == 24'h000000))
      else $error("flag cleared by a write elsewhere");

   a_mask_write: assert property (
      (wr_ok && addr_in == `PIFM_OFF_IRQ_MASK) |=>
      (mask_r == $past(wdata_in[1:0])))
      else $error("mask write not taken");

   a_stat_masked: assert property (
      ((wr_in || rd_in) && !iface_unmask_in) |=>
      stat_q[`PIFM_STAT_MASKED])
      else $error("refused access not flagged");

   a_flag_mid_bits: assert property (
      (serial_controller_flags_set_in[5] && can_flag_set_in
       && adc_flags_set_in[1]) |=>
      (flags_q[6] && flags_q[7] && flags_q[18]))
      else $error("serial, CAN or converter flag misplaced");

   a_line_pairs: assert property (
      ##1 (irq_line_out[10] == $past(serial_req_in[1] | serial_req_in[7]))
      && (irq_line_out[14] == $past(serial_req_in[5]))
      && (irq_line_out[16] == $past(can_req_in[1]))
      && (irq_line_out[22] == $past(btimer_req_in[2] | btimer_req_in[7])))
      else $error("paired line routing wrong");

   c_flag_clear: cover property (
      (flags_q != 24'h000000) ##1 (wr_ok && addr_in == `PIFM_OFF_FLAG_CLR)
      ##1 (flags_q == 24'h000000));
   c_masked_read: cover property (rd_in && !iface_unmask_in);
   c_irq_raised: cover property (!irq_out ##1 irq_out);
   c_set_and_clear: cover property (
      (wr_ok && addr_in == `PIFM_OFF_FLAG_CLR && |(flag_set & wdata_in[23:0])));
   c_clk_req: cover property (!clk_src_req_out ##1 clk_src_req_out);
endmodule // pifm_top

//--- shared/pifm_map.svh
// offsets, bit positions, reset values and line numbers of the flag map
`ifndef PIFM_MAP_SVH
`define PIFM_MAP_SVH

// register offsets (byte addresses)
`define PIFM_OFF_FLAG_CLR    8'h1C
`define PIFM_OFF_IRQ_STAT    8'h20
`define PIFM_OFF_IRQ_MASK    8'h24

// reset values
`define PIFM_RST_FLAGS       24'h000000
`define PIFM_RST_STAT        2'h0
`define PIFM_RST_MASK        2'h0
`define PIFM_RST_WORD        32'h00000000

// implemented flag bits; bit 8 and bits 31:24 hold nothing
`define PIFM_FLAG_IMPL       24'hFFFEFF

// flag positions in the collection register
`define PIFM_BIT_CUSTOM      23
`define PIFM_BIT_TOUCH       22
`define PIFM_BIT_DAC         21
`define PIFM_BIT_CMP         20
`define PIFM_BIT_SIGMA       19
`define PIFM_BIT_ADC_LO      17
`define PIFM_BIT_BTIMER_LO   12
`define PIFM_BIT_CTIMER_LO   9
`define PIFM_BIT_CAN         7
`define PIFM_BIT_SERIAL_LO   1
`define PIFM_BIT_EVENT       0

// instance counts behind the flags
`define PIFM_N_ADC_FLAGS     2
`define PIFM_N_BTIMER_FLAGS  5
`define PIFM_N_CTIMER_FLAGS  3
`define PIFM_N_SERIAL_FLAGS  6

// interrupt status bits
`define PIFM_STAT_RAISED     0
`define PIFM_STAT_MASKED     1

// processor interrupt line numbers
`define PIFM_LINE_EVENT      8
`define PIFM_LINE_SERIAL_LO  9
`define PIFM_LINE_CAN_LO     15
`define PIFM_LINE_CTIMER_LO  17
`define PIFM_LINE_BTIMER_LO  20
`define PIFM_LINE_BTIMER3    23
`define PIFM_LINE_BTIMER4    24
`define PIFM_LINE_ADC_LO     25
`define PIFM_LINE_CMP        27
`define PIFM_LINE_DAC        28
`define PIFM_LINE_SIGMA      29
`define PIFM_LINE_TOUCH      30
`define PIFM_LINE_RSVD       31

`endif

//--- shared/pifm_pkg.sv
// types shared by the flag map design
package pifm_pkg;
   typedef logic [7:0]  pifm_addr_type;
   typedef logic [31:0] pifm_word_type;
   typedef logic [23:0] pifm_flags_type;
   typedef logic [1:0]  pifm_stat_type;
endpackage

//--- tb/testbench.sv
// self-checking bench for the peripheral flag collector and line map
`timescale 1ns/10ps
`include "pifm_map.svh"
module testbench;
   import pifm_pkg::*;
   logic          clk_in          = 1'b0;
   logic          reset_n_in      = 1'b0;
   pifm_addr_type addr_in         = 8'h00;
   pifm_word_type wdata_in        = 32'h00000000;
   logic          wr_in           = 1'b0;
   logic          rd_in           = 1'b0;
   pifm_word_type rdata_out;
   logic          iface_unmask_in = 1'b1;
   logic [23:0]   set_v           = 24'h000000;
   logic [27:0]   req_v           = 28'h0000000;
   logic [31:0]   irq_line_out;
   logic [3:0]    clk_req_in      = 4'h0;
   logic [3:0]    periph_en_in    = 4'h0;
   logic [3:0]    gen_clk_en_in   = 4'h0;
   logic [3:0]    generator_en_in = 4'h0;
   logic          clk_src_req_out;
   logic          irq_out;
   int            miscompares     = 0;
   int            samples_checked = 0;

   always #10 clk_in = ~clk_in;

   // set_v[8] stays unconnected: no flag lives there
   pifm_top #(.N_CLK_REQ(4)) pifm_top_inst (
      .clk_in                            (clk_in),
      .reset_n_in                        (reset_n_in),
      .addr_in                           (addr_in),
      .wdata_in                          (wdata_in),
      .wr_in                             (wr_in),
      .rd_in                             (rd_in),
      .rdata_out                         (rdata_out),
      .iface_unmask_in                   (iface_unmask_in),
      .event_system_flag_set_in          (set_v[0]),
      .serial_controller_flags_set_in    (set_v[6:1]),
      .can_flag_set_in                   (set_v[7]),
      .control_timer_flags_set_in        (set_v[11:9]),
      .basic_timer_flags_set_in          (set_v[16:12]),
      .adc_flags_set_in                  (set_v[18:17]),
      .sigma_delta_converter_flag_set_in (set_v[19]),
      .comparator_flag_set_in            (set_v[20]),
      .dac_flag_set_in                   (set_v[21]),
      .touch_controller_flag_set_in      (set_v[22]),
      .custom_logic_flag_set_in          (set_v[23]),
      .event_req_in                      (req_v[0]),
      .serial_req_in                     (req_v[8:1]),
      .can_req_in                        (req_v[10:9]),
      .ctimer_req_in                     (req_v[13:11]),
      .btimer_req_in                     (req_v[21:14]),
      .adc_req_in                        (req_v[23:22]),
      .comparator_req_in                 (req_v[24]),
      .dac_req_in                        (req_v[25]),
      .sigma_req_in                      (req_v[26]),
      .touch_req_in                      (req_v[27]),
      .irq_line_out                      (irq_line_out),
      .clk_req_in                        (clk_req_in),
      .periph_en_in                      (periph_en_in),
      .gen_clk_en_in                     (gen_clk_en_in),
      .generator_en_in                   (generator_en_in),
      .clk_src_req_out                   (clk_src_req_out),
      .irq_out                           (irq_out)
   );

   task automatic finish_test();
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk_word(input string n, input pifm_word_type e,
                           input pifm_word_type g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_bit(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic bus_wr(input pifm_addr_type a, input pifm_word_type d);
      @(posedge clk_in);
      wr_in    <= 1'b1;
      addr_in  <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe edge
   task automatic reg_chk(input pifm_addr_type a, input pifm_word_type e);
      @(posedge clk_in);
      rd_in   <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk_word("read data", e, rdata_out);
   endtask

   task automatic pulse_set(input logic [23:0] m);
      @(posedge clk_in);
      set_v <= m;
      @(posedge clk_in);
      set_v <= 24'h000000;
   endtask

   // shared lines make the index-to-line step irregular
   function automatic int line_of(input int k);
      if (k == 0) return 8;
      if (k <= 6) return 8 + k;
      if (k <= 8) return 2 + k;
      if (k <= 18) return k + 6;
      if (k <= 21) return k + 1;
      return k + 3;
   endfunction

   task automatic t_reset();
      reg_chk(`PIFM_OFF_FLAG_CLR, 32'h00000000);
      reg_chk(`PIFM_OFF_IRQ_STAT, 32'h00000000);
      reg_chk(`PIFM_OFF_IRQ_MASK, 32'h00000000);
      reg_chk(8'h30, 32'h00000000);
      chk_word("lines", 32'h00000000, irq_line_out);
      chk_bit("irq", 1'b0, irq_out);
   endtask

   task automatic t_flag_map();
      for (int i = 0; i < 24; i++) begin
         if (i != 8) begin
            pulse_set(24'h000001 << i);
            reg_chk(`PIFM_OFF_FLAG_CLR, 32'h1 << i);
            bus_wr(`PIFM_OFF_FLAG_CLR, 32'h1 << i);
            reg_chk(`PIFM_OFF_FLAG_CLR, 32'h00000000);
         end
      end
   endtask

   task automatic t_w1c();
      pulse_set(24'hFFFFFF);
      reg_chk(`PIFM_OFF_FLAG_CLR, 32'h00FFFEFF);
      bus_wr(`PIFM_OFF_FLAG_CLR, 32'h00000000);
      reg_chk(`PIFM_OFF_FLAG_CLR, 32'h00FFFEFF);
      bus_wr(`PIFM_OFF_FLAG_CLR, 32'hFF000100);
      reg_chk(`PIFM_OFF_FLAG_CLR, 32'h00FFFEFF);
      bus_wr(`PIFM_OFF_FLAG_CLR, 32'h00F0F00F);
      reg_chk(`PIFM_OFF_FLAG_CLR, 32'h000F0EF0);
      bus_wr(`PIFM_OFF_FLAG_CLR, 32'hFFFFFFFF);
      reg_chk(`PIFM_OFF_FLAG_CLR, 32'h00000000);
   endtask

   task automatic t_lines();
      for (int k = 0; k < 28; k++) begin
         @(posedge clk_in);
         req_v <= 28'h0000001 << k;
         cyc(2);
         #1;
         chk_word("line", 32'h1 << line_of(k), irq_line_out);
      end
      @(posedge clk_in);
      req_v <= 28'hFFFFFFF;
      cyc(2);
      #1;
      chk_word("all lines", 32'h7FFFFF00, irq_line_out);
      @(posedge clk_in);
      req_v <= 28'h0000000;
   endtask

   task automatic t_gate();
      bus_wr(`PIFM_OFF_IRQ_STAT, 32'h00000003);
      pulse_set(24'h200000);
      @(posedge clk_in);
      iface_unmask_in <= 1'b0;
      reg_chk(`PIFM_OFF_FLAG_CLR, 32'h00000000);
      bus_wr(`PIFM_OFF_FLAG_CLR, 32'hFFFFFFFF);
      bus_wr(`PIFM_OFF_IRQ_MASK, 32'h00000003);
      @(posedge clk_in);
      iface_unmask_in <= 1'b1;
      reg_chk(`PIFM_OFF_FLAG_CLR, 32'h00200000);
      reg_chk(`PIFM_OFF_IRQ_MASK, 32'h00000000);
      reg_chk(`PIFM_OFF_IRQ_STAT, 32'h00000003);
      bus_wr(`PIFM_OFF_IRQ_STAT, 32'h00000003);
      reg_chk(`PIFM_OFF_IRQ_STAT, 32'h00000000);
      bus_wr(`PIFM_OFF_FLAG_CLR, 32'hFFFFFFFF);
   endtask

   task automatic t_irq();
      pulse_set(24'h000001);
      reg_chk(`PIFM_OFF_IRQ_STAT, 32'h00000001);
      chk_bit("irq masked", 1'b0, irq_out);
      bus_wr(`PIFM_OFF_IRQ_MASK, 32'h00000001);
      cyc(2);
      #1;
      chk_bit("irq open", 1'b1, irq_out);
      reg_chk(`PIFM_OFF_IRQ_MASK, 32'h00000001);
      bus_wr(`PIFM_OFF_IRQ_STAT, 32'h00000001);
      cyc(2);
      #1;
      chk_bit("irq cleared", 1'b0, irq_out);
      bus_wr(`PIFM_OFF_FLAG_CLR, 32'hFFFFFFFF);
   endtask

   task automatic t_clkreq();
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_in);
         clk_req_in      <= 4'h4;
         periph_en_in    <= {4{c[0]}};
         gen_clk_en_in   <= {4{c[1]}};
         generator_en_in <= {4{c[2]}};
         cyc(2);
         #1;
         chk_bit("clock request", c == 7, clk_src_req_out);
      end
      // enables of another channel must not pass this request
      @(posedge clk_in);
      clk_req_in      <= 4'h2;
      periph_en_in    <= 4'h4;
      gen_clk_en_in   <= 4'h4;
      generator_en_in <= 4'h4;
      cyc(2);
      #1;
      chk_bit("crossed request", 1'b0, clk_src_req_out);
   endtask

   // set, read, clear and read with no idle cycle between strobes
   task automatic t_burst();
      @(posedge clk_in);
      set_v <= 24'h800000;
      @(posedge clk_in);
      set_v   <= 24'h000000;
      rd_in   <= 1'b1;
      addr_in <= `PIFM_OFF_FLAG_CLR;
      @(posedge clk_in);
      rd_in    <= 1'b0;
      wr_in    <= 1'b1;
      wdata_in <= 32'h00800000;
      #1;
      chk_word("read after set", 32'h00800000, rdata_out);
      @(posedge clk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b1;
      #1;
      chk_word("read data one cycle later", 32'h00000000, rdata_out);
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk_word("read after clear", 32'h00000000, rdata_out);
   endtask

   // a raise in the clearing cycle must survive the clear
   task automatic t_race();
      @(posedge clk_in);
      set_v    <= 24'h000080;
      wr_in    <= 1'b1;
      addr_in  <= `PIFM_OFF_FLAG_CLR;
      wdata_in <= 32'h00000080;
      @(posedge clk_in);
      set_v <= 24'h000000;
      wr_in <= 1'b0;
      reg_chk(`PIFM_OFF_FLAG_CLR, 32'h00000080);
      bus_wr(`PIFM_OFF_FLAG_CLR, 32'h00000080);
      reg_chk(`PIFM_OFF_FLAG_CLR, 32'h00000000);
   endtask

   // reset in mid-run drops flags, status, mask and the interrupt
   task automatic t_mid_reset();
      pulse_set(24'h000001);
      bus_wr(`PIFM_OFF_IRQ_MASK, 32'h00000001);
      cyc(2);
      #1;
      chk_bit("irq before reset", 1'b1, irq_out);
      @(posedge clk_in);
      reset_n_in <= 1'b0;
      cyc(3);
      reset_n_in <= 1'b1;
      t_reset();
   endtask

   initial begin
      #1000000;
      miscompares++;
      finish_test();
   end

   initial begin
      cyc(10);
      reset_n_in <= 1'b1;
      t_reset();
      t_flag_map();
      t_w1c();
      t_burst();
      t_race();
      t_lines();
      t_gate();
      t_irq();
      t_mid_reset();
      t_clkreq();
      finish_test();
   end
endmodule // testbench
